// File: hssc_consts.vh
// constants for the high-side supply supervisor control block
`ifndef HSSC_CONSTS_VH
`define HSSC_CONSTS_VH
// register byte addresses
`define HSSC_ADDR_PWD 8'h00
`define HSSC_ADDR_AUX 8'h02
`define HSSC_ADDR_HSC 8'h04
`define HSSC_ADDR_IFG 8'h0C
`define HSSC_ADDR_IMASK 8'h0E
// password byte
`define HSSC_PWD_UNLOCK 8'hA5
`define HSSC_PWD_READ 8'h96
// high-side control fields
`define HSSC_B_MFP 15
`define HSSC_B_MEN 14
`define HSSC_B_OVP 12
`define HSSC_B_SFP 11
`define HSSC_B_SEN 10
`define HSSC_B_ACE 7
`define HSSC_B_EVM 6
`define HSSC_B_SMD 4
`define HSSC_B_DLY 3
`define HSSC_RST_HSC 16'h4400
`define HSSC_WMASK_HSC 16'hDFD7
`define HSSC_WMASK_AUX 16'h0033
// event status bits
`define HSSC_EV_SUP 0
`define HSSC_EV_MON 1
`define HSSC_EV_OVP 2
`define HSSC_EV_DLY 3
// delay times in ns, and cycle counts at 10 ns
`define HSSC_DLY_SLOW_NS 2000
`define HSSC_DLY_FAST_NS 500
`define HSSC_CLK_NS 10
// sized to the 16-bit delay counter so the load drops no bits
`define HSSC_DLY_SLOW_CYC 16'h00C8
`define HSSC_DLY_FAST_CYC 16'h0032
`endif

// File: hssc_delay.v
// settle-delay timer that masks high-side events
`timescale 1ns/1ns
`default_nettype none
`include "hssc_consts.vh"
module hssc_delay (
  input wire clock,
  input wire rst,
  // control
  input wire start,
  input wire fast,
  // status
  output reg busy
);
  reg [15:0] count;

  // shorter delay when both circuits run full performance
  always @(posedge clock) begin
    if (rst) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else if (start) begin
      count <= fast ? `HSSC_DLY_FAST_CYC : `HSSC_DLY_SLOW_CYC;
      busy <= 1'b1;
    end else if (busy) begin
      if (count == 16'h0001) begin
        busy <= 1'b0; // hardware clears on expiry
      end
      count <= count - 16'h0001;
    end
  end
endmodule // hssc_delay
`default_nettype wire

// File: hssc_evgate.v
// gates raw comparator events into qualified event pulses
`timescale 1ns/1ns
`default_nettype none
module hssc_evgate (
  input wire clock,
  input wire rst,
  // comparator levels
  input wire sup_fail,
  input wire mon_low,
  input wire mon_over,
  // qualifiers
  input wire sup_en,
  input wire mon_en,
  input wire ovp_en,
  input wire masked,
  input wire in_deep_lpm,
  input wire lpm_flag_mode,
  // qualified rising-edge events
  output reg [2:0] ev
);
  reg [2:0] prev;
  wire [2:0] live;

  // deep low-power modes suppress the supervisor flag unless mode bit set
  assign live[0] = sup_en & sup_fail & (~in_deep_lpm | lpm_flag_mode);
  assign live[1] = mon_en & mon_low;
  assign live[2] = mon_en & ovp_en & mon_over;

  // edge detect so a held fault raises one event only
  always @(posedge clock) begin
    if (rst) begin
      prev <= 3'h0;
      ev <= 3'h0;
    end else begin
      prev <= live;
      ev <= masked ? 3'h0 : (live & ~prev);
    end
  end
endmodule // hssc_evgate
`default_nettype wire

// File: hssc_top.v
// register bank and control for the high-side supply supervisor
`timescale 1ns/1ns
`default_nettype none
`include "hssc_consts.vh"
// Notes on behaviour
// - monitor enable bit 14, reset 1, switches the high-side monitor
// - supervisor enable bit 10, reset 1, switches the high-side supervisor
// - bit 15 selects monitor full performance or normal mode
// - bit 11 selects supervisor full performance or normal mode
// - bit 12 enables overvoltage detect; with level reset enable it raises power-on reset
// - bits 9-8 pick reset threshold; supply drop resets when reset enable set
// - bits 2-0 pick release threshold and monitor reached level
// - bit 7 hands low-power mode choice to hardware
// - bit 6 masks supervisor, monitor and overvoltage events, not the delay expiry event
// - bit 4 lets power-fail set supervisor flag in deep sleep modes
// - bit 3 read-only delay status masks events, hardware clears on expiry
// - reserved read-only bits read as zero
// - HSC and AUX writes need password unlock byte; other value relocks; reads fixed
module hssc_top (
  input wire clock,
  input wire rst,
  // avalon-mm slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [1:0] byteenable,
  input wire [15:0] writedata,
  output reg [15:0] readdata,
  output reg waitrequest,
  output reg irq,
  // analog comparator results and qualifiers
  input wire sup_fail,
  input wire mon_low,
  input wire mon_over,
  input wire in_deep_lpm,
  input wire hw_lpm_request,
  input wire sup_reset_en,
  input wire mon_level_reset_en,
  // analog controls
  output reg mon_enable,
  output reg sup_enable,
  output reg mon_full_perf,
  output reg sup_full_perf,
  output reg ovp_enable,
  output reg [1:0] reset_level,
  output reg [2:0] release_level,
  output reg analog_lpm,
  output reg reset_request,
  output reg por_request
);
  reg [15:0] hsc;
  reg [15:0] aux;
  reg [3:0] ifg;
  reg [3:0] imask;
  reg unlocked;
  reg busy_phase;
  reg dly_start;
  wire dly_busy;
  wire [2:0] ev;
  wire [15:0] hsc_view;
  wire hit;
  wire do_write;
  wire do_read;
  reg [15:0] next_readdata;
  reg [3:0] next_ifg;
  wire [3:0] ev_all;

  // one wait state: the access completes on the second edge
  assign hit = (read | write) & busy_phase;
  assign do_write = write & busy_phase;
  assign do_read = read & busy_phase;

  // status bit is live delay state, reserved bits zero
  assign hsc_view = (hsc & `HSSC_WMASK_HSC) | {12'h000, dly_busy, 3'h0};

  hssc_delay u_delay (
    .clock(clock),
    .rst(rst),
    .start(dly_start),
    .fast(hsc[`HSSC_B_MFP] & hsc[`HSSC_B_SFP]),
    .busy(dly_busy)
  );

  hssc_evgate u_evgate (
    .clock(clock),
    .rst(rst),
    .sup_fail(sup_fail),
    .mon_low(mon_low),
    .mon_over(mon_over),
    .sup_en(hsc[`HSSC_B_SEN]),
    .mon_en(hsc[`HSSC_B_MEN]),
    .ovp_en(hsc[`HSSC_B_OVP]),
    .masked(hsc[`HSSC_B_EVM] | dly_busy),
    .in_deep_lpm(in_deep_lpm),
    .lpm_flag_mode(hsc[`HSSC_B_SMD]),
    .ev(ev)
  );

  // delay expiry is a status event too
  reg dly_prev;
  assign ev_all = {dly_prev & ~dly_busy, ev};

  // bus handshake phase
  always @(posedge clock) begin
    if (rst) begin
      busy_phase <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      busy_phase <= (read | write) & ~busy_phase;
      waitrequest <= ~((read | write) & ~busy_phase);
    end
  end

  // password byte, HSC and AUX writes only when unlocked
  always @(posedge clock) begin
    if (rst) begin
      unlocked <= 1'b0;
      hsc <= `HSSC_RST_HSC;
      aux <= 16'h0000;
      imask <= 4'h0;
      dly_start <= 1'b0;
    end else begin
      dly_start <= 1'b0;
      if (do_write && address == `HSSC_ADDR_PWD && byteenable[1]) begin
        unlocked <= (writedata[15:8] == `HSSC_PWD_UNLOCK);
      end
      if (do_write && unlocked && address == `HSSC_ADDR_HSC) begin
        // read-only and reserved bits are written as zero
        if (byteenable[0]) begin
          hsc[7:0] <= writedata[7:0] & 8'hD7;
        end
        if (byteenable[1]) begin
          hsc[15:8] <= writedata[15:8] & 8'hDF;
        end
        // reprogramming the circuits restarts the settle delay
        dly_start <= 1'b1;
      end
      if (do_write && unlocked && address == `HSSC_ADDR_AUX && byteenable[0]) begin
        aux[7:0] <= writedata[7:0] & 8'h33;
      end
      if (do_write && address == `HSSC_ADDR_IMASK && byteenable[0]) begin
        imask <= writedata[3:0];
      end
    end
  end

  // sticky event flags; a set in the clearing cycle wins
  always @* begin
    next_ifg = ifg;
    // clear only what the read returned, so a flag raised mid-read survives
    if (do_read && address == `HSSC_ADDR_IFG) begin
      next_ifg = ifg & ~readdata[3:0];
    end
    next_ifg = next_ifg | ev_all;
  end

  always @(posedge clock) begin
    if (rst) begin
      ifg <= 4'h0;
      dly_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      ifg <= next_ifg;
      dly_prev <= dly_busy;
      irq <= |(next_ifg & imask);
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    case (address)
      `HSSC_ADDR_PWD: next_readdata = {`HSSC_PWD_READ, 8'h00};
      `HSSC_ADDR_AUX: next_readdata = aux & `HSSC_WMASK_AUX;
      `HSSC_ADDR_HSC: next_readdata = hsc_view;
      `HSSC_ADDR_IFG: next_readdata = {12'h000, ifg};
      `HSSC_ADDR_IMASK: next_readdata = {12'h000, imask};
      default: next_readdata = 16'h0000;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      readdata <= 16'h0000;
    end else if (read & ~busy_phase) begin
      readdata <= next_readdata;
    end
  end

  // analog control outputs, all registered
  always @(posedge clock) begin
    if (rst) begin
      mon_enable <= 1'b1;
      sup_enable <= 1'b1;
      mon_full_perf <= 1'b0;
      sup_full_perf <= 1'b0;
      ovp_enable <= 1'b0;
      reset_level <= 2'h0;
      release_level <= 3'h0;
      analog_lpm <= 1'b0;
      reset_request <= 1'b0;
      por_request <= 1'b0;
    end else begin
      mon_enable <= hsc[`HSSC_B_MEN];
      sup_enable <= hsc[`HSSC_B_SEN];
      mon_full_perf <= hsc[`HSSC_B_MFP];
      sup_full_perf <= hsc[`HSSC_B_SFP];
      ovp_enable <= hsc[`HSSC_B_OVP];
      reset_level <= hsc[9:8];
      release_level <= hsc[2:0];
      // hardware decides lpm only under automatic control
      analog_lpm <= hsc[`HSSC_B_ACE] & hw_lpm_request;
      reset_request <= hsc[`HSSC_B_SEN] & sup_fail & sup_reset_en;
      por_request <= hsc[`HSSC_B_MEN] & hsc[`HSSC_B_OVP] & mon_over
        & mon_level_reset_en;
    end
  end
endmodule // hssc_top
`default_nettype wire

// File: hssc_assertions.sv
// port assertions for the supervisor control block
`timescale 1ns/1ns
`default_nettype none
module hssc_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // comparator and qualifier inputs
  input wire logic sup_fail,
  input wire logic mon_over,
  input wire logic hw_lpm_request,
  input wire logic sup_reset_en,
  input wire logic mon_level_reset_en,
  // analog controls
  input wire logic mon_enable,
  input wire logic sup_enable,
  input wire logic ovp_enable,
  input wire logic [1:0] reset_level,
  input wire logic [2:0] release_level,
  input wire logic analog_lpm,
  input wire logic reset_request,
  input wire logic por_request
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("answer held over two cycles");
  a_rst_request: assert property (sup_enable && sup_fail && sup_reset_en |=> reset_request)
    else $error("supply drop gave no reset request");
  a_rst_gate: assert property (!sup_fail || !sup_reset_en |=> !reset_request)
    else $error("reset request without cause");
  a_por_request: assert property (mon_enable && ovp_enable && mon_over && mon_level_reset_en
    |=> por_request)
    else $error("overvoltage gave no power-on reset");
  a_por_gate: assert property (!ovp_enable |=> !por_request)
    else $error("power-on reset with overvoltage off");
  a_lpm_gate: assert property (!hw_lpm_request |=> !analog_lpm)
    else $error("low-power mode without hardware request");
  // controls move only as the echo of a bus write, which spans two cycles
  a_ctl_by_write: assert property ($changed({mon_enable, sup_enable, ovp_enable, reset_level,
    release_level}) |-> $past(write) || $past(write, 2))
    else $error("control output changed without a write");
endmodule // hssc_chk
`default_nettype wire

// File: hssc_top_test.sv
// self-checking bench for the supervisor control block
`timescale 1ns/1ns
`default_nettype none
`include "hssc_consts.vh"
module hssc_top_test;
  logic clock = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
  logic [7:0] address = 8'h00;
  logic [1:0] byteenable = 2'h3;
  logic [15:0] writedata = 16'h0000, rd;
  logic sup_fail = 1'h0, mon_low = 1'h0, mon_over = 1'h0, in_deep_lpm = 1'h0;
  logic hw_lpm_request = 1'h0, sup_reset_en = 1'h1, mon_level_reset_en = 1'h1;
  wire [15:0] readdata;
  wire waitrequest, irq, mon_enable, sup_enable, mon_full_perf, sup_full_perf;
  wire ovp_enable, analog_lpm, reset_request, por_request;
  wire [1:0] reset_level;
  wire [2:0] release_level;
  int n_fail = 0, checks_done = 0;
  hssc_top DUT (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one transfer, held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic w, input logic [7:0] a, input logic [1:0] be,
    input logic [15:0] d);
    int t;
    address <= a;
    byteenable <= be;
    writedata <= d;
    read <= !w;
    write <= w;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (waitrequest !== 1'h0 && t < 50);
    if (waitrequest !== 1'h0) n_fail++;
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'h1, a, 2'h3, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 2'h3, 16'h0000);
    chk("reg", rd, e);
  endtask
  task automatic t_regs;
    chk("ctl", {11'h000, mon_full_perf, mon_enable, ovp_enable, sup_full_perf, sup_enable},
      16'h0009);
    rdc(`HSSC_ADDR_HSC, 16'h4400);
    rdc(`HSSC_ADDR_AUX, 16'h0000);
    rdc(`HSSC_ADDR_PWD, 16'h9600);
    wr(`HSSC_ADDR_HSC, 16'hFFFF);
    rdc(`HSSC_ADDR_HSC, 16'h4400);
    bus(1'h1, `HSSC_ADDR_PWD, 2'h2, 16'hA500);
    wr(`HSSC_ADDR_HSC, 16'hFFFF);
    rdc(`HSSC_ADDR_HSC, 16'hDFDF);
    chk("ctl", {6'h00, mon_full_perf, mon_enable, ovp_enable, sup_full_perf, sup_enable,
      reset_level, release_level}, 16'h03FF);
    // both full-performance bits set: short delay
    repeat (60) @(posedge clock);
    rdc(`HSSC_ADDR_HSC, 16'hDFD7);
    wr(`HSSC_ADDR_HSC, 16'h0000);
    rdc(`HSSC_ADDR_HSC, 16'h0008);
    chk("ctl", {11'h000, mon_full_perf, mon_enable, ovp_enable, sup_full_perf, sup_enable},
      16'h0000);
    repeat (60) @(posedge clock);
    rdc(`HSSC_ADDR_HSC, 16'h0008);
    repeat (150) @(posedge clock);
    rdc(`HSSC_ADDR_HSC, 16'h0000);
    // ones only on reserved read-only bits; the writable fields get zero
    wr(`HSSC_ADDR_AUX, 16'hFFCC);
    rdc(`HSSC_ADDR_AUX, 16'h0000);
    wr(`HSSC_ADDR_AUX, 16'h0000);
    wr(8'h40, 16'hFFFF);
    bus(1'h1, `HSSC_ADDR_PWD, 2'h2, 16'h0000);
    wr(`HSSC_ADDR_HSC, 16'hFFFF);
    rdc(`HSSC_ADDR_HSC, 16'h0000);
  endtask
  // pulse comparators, check the interrupt, then read status which clears it
  task automatic fire(input logic [2:0] v, input logic ei, input logic [2:0] es);
    {mon_over, mon_low, sup_fail} <= v;
    repeat (4) @(posedge clock);
    chk("irq", {15'h0000, irq}, {15'h0000, ei});
    {mon_over, mon_low, sup_fail} <= 3'h0;
    @(posedge clock);
    bus(1'h0, `HSSC_ADDR_IFG, 2'h3, 16'h0000);
    chk("status", {13'h0000, rd[2:0]}, {13'h0000, es});
    @(posedge clock);
    chk("irq", {15'h0000, irq}, 16'h0000);
  endtask
  task automatic hsc(input logic [15:0] d);
    wr(`HSSC_ADDR_HSC, d);
    repeat (220) @(posedge clock);
  endtask
  // supply drop and overvoltage requests follow their enable inputs
  task automatic t_resets;
    sup_fail <= 1'h1;
    mon_over <= 1'h1;
    repeat (2) @(posedge clock);
    chk("rst_req", {14'h0000, reset_request, por_request}, 16'h0003);
    sup_reset_en <= 1'h0;
    mon_level_reset_en <= 1'h0;
    repeat (2) @(posedge clock);
    chk("rst_req", {14'h0000, reset_request, por_request}, 16'h0000);
    {mon_over, sup_fail, sup_reset_en, mon_level_reset_en} <= 4'h3;
  endtask
  task automatic t_events;
    bus(1'h1, `HSSC_ADDR_PWD, 2'h2, 16'hA500);
    wr(`HSSC_ADDR_IMASK, 16'h0007);
    hsc(16'h4400);
    bus(1'h0, `HSSC_ADDR_IFG, 2'h3, 16'h0000);
    fire(3'h1, 1'h1, 3'h1);
    fire(3'h4, 1'h0, 3'h0);
    hsc(16'h5400);
    fire(3'h4, 1'h1, 3'h4);
    hsc(16'h5440);
    fire(3'h1, 1'h0, 3'h0);
    wr(`HSSC_ADDR_HSC, 16'h5400);
    fire(3'h2, 1'h0, 3'h0);
    repeat (220) @(posedge clock);
    in_deep_lpm <= 1'h1;
    fire(3'h1, 1'h0, 3'h0);
    hsc(16'h5410);
    fire(3'h1, 1'h1, 3'h1);
    in_deep_lpm <= 1'h0;
    wr(`HSSC_ADDR_IMASK, 16'h0000);
    fire(3'h2, 1'h0, 3'h2);
    t_resets;
    // hardware request alone does nothing until automatic control is set
    hw_lpm_request <= 1'h1;
    repeat (3) @(posedge clock);
    chk("lpm", {15'h0000, analog_lpm}, 16'h0000);
    wr(`HSSC_ADDR_HSC, 16'h4480);
    repeat (3) @(posedge clock);
    chk("lpm", {15'h0000, analog_lpm}, 16'h0001);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_regs;
    t_events;
    tally_and_finish;
  end
  // watchdog, well beyond the fewer than two thousand cycles the run needs
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
endmodule // hssc_top_test
bind hssc_top hssc_chk u_chk (.*);
`default_nettype wire
